/* File: src/sfb_master.sv */
// serial flash boot master: mode 0 serial port with three active-low selects
module sfb_master (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_slave,
  input wire logic [7:0] req_data,
  input wire logic req_last,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic cmd_error,
  output logic sclk,
  output logic master_out_line,
  input wire logic master_in_line,
  output logic [2:0] select_line_n
);

  function automatic logic is_erase(input logic [7:0] op);
    return op == sfb_pkg::OP_ERASE_SECTOR || op == sfb_pkg::OP_ERASE_BLOCK ||
      op == sfb_pkg::OP_ERASE_CHIP;
  endfunction : is_erase

  sfb_pkg::sfb_state_t state;
  logic [2:0] cnt;
  logic [2:0] bit_idx;
  logic [7:0] tx;
  logic [7:0] rx;
  logic [1:0] slave;
  logic last_q;
  logic erase_pend;
  logic [2:0] erased;
  logic accept;
  logic refuse;

  assign req_ready = (state == sfb_pkg::ST_IDLE) || (state == sfb_pkg::ST_GAP);
  assign accept = req_valid && req_ready;
  // an unused select index or a program to a slave never erased is turned away
  assign refuse = (state == sfb_pkg::ST_IDLE) && ((req_slave == 2'h3) ||
    (req_data == sfb_pkg::OP_PROGRAM && !erased[req_slave]));
  assign master_out_line = tx[7];

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= sfb_pkg::ST_IDLE;
      cnt <= 3'h0;
      bit_idx <= 3'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      slave <= 2'h0;
      last_q <= 1'b0;
      sclk <= 1'b0;
      select_line_n <= sfb_pkg::SEL_IDLE;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      cmd_error <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      cmd_error <= 1'b0;
      unique case (state)
        sfb_pkg::ST_IDLE: begin
          if (accept && refuse) begin
            cmd_error <= 1'b1;
          end else if (accept) begin
            // one select only, first bit shown while the lead runs
            select_line_n <= ~(3'h1 << req_slave);
            slave <= req_slave;
            tx <= req_data;
            last_q <= req_last;
            bit_idx <= 3'h0;
            cnt <= sfb_pkg::LEAD_RELOAD;
            state <= sfb_pkg::ST_LEAD;
          end
        end
        sfb_pkg::ST_LEAD: begin
          if (cnt == 3'h0) begin
            state <= sfb_pkg::ST_SHIFT;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        sfb_pkg::ST_SHIFT: begin
          if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
          end else if (!sclk) begin
            cnt <= sfb_pkg::HALF_RELOAD;
            sclk <= 1'b1;
            rx <= {rx[6:0], master_in_line};
          end else begin
            cnt <= sfb_pkg::HALF_RELOAD;
            sclk <= 1'b0;
            if (bit_idx == sfb_pkg::LAST_BIT) begin
              rsp_valid <= 1'b1;
              rsp_data <= rx;
              cnt <= sfb_pkg::LAG_RELOAD;
              state <= last_q ? sfb_pkg::ST_LAG : sfb_pkg::ST_GAP;
            end else begin
              bit_idx <= bit_idx + 3'h1;
              tx <= {tx[6:0], 1'b0};
            end
          end
        end
        sfb_pkg::ST_GAP: begin
          // clock parked low, select kept; next byte gets a full low half
          if (accept) begin
            tx <= req_data;
            last_q <= req_last;
            bit_idx <= 3'h0;
            cnt <= sfb_pkg::HALF_RELOAD;
            state <= sfb_pkg::ST_SHIFT;
          end
        end
        sfb_pkg::ST_LAG: begin
          if (cnt == 3'h0) begin
            select_line_n <= sfb_pkg::SEL_IDLE;
            state <= sfb_pkg::ST_IDLE;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // erase tracking per slave; a whole-device view, not per region
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      erase_pend <= 1'b0;
      erased <= 3'h0;
    end else begin
      if (state == sfb_pkg::ST_IDLE && accept && !refuse) begin
        erase_pend <= is_erase(req_data);
      end
      if (state == sfb_pkg::ST_LAG && cnt == 3'h0 && erase_pend) begin
        erased[slave] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_one_select;
    @(posedge clk) disable iff (!arst_n) $countones(~select_line_n) <= 1;
  endproperty
  a_one_select: assert property (p_one_select) else $error("two selects low");

  property p_clock_in_frame;
    @(posedge clk) disable iff (!arst_n) sclk |-> select_line_n != sfb_pkg::SEL_IDLE;
  endproperty
  a_clock_in_frame: assert property (p_clock_in_frame) else $error("clock outside frame");

  property p_high_half;
    @(posedge clk) disable iff (!arst_n) $rose(sclk) |-> sclk[*2] ##1 !sclk;
  endproperty
  a_high_half: assert property (p_high_half) else $error("clock high phase wrong");

  property p_low_half;
    @(posedge clk) disable iff (!arst_n)
      $fell(sclk) && state == sfb_pkg::ST_SHIFT |-> !sclk[*2] ##1 sclk;
  endproperty
  a_low_half: assert property (p_low_half) else $error("clock low phase wrong");

  property p_data_steady_high;
    @(posedge clk) disable iff (!arst_n) sclk |-> $stable(master_out_line);
  endproperty
  a_data_steady_high: assert property (p_data_steady_high) else $error("data moved");

  property p_capture;
    @(posedge clk) disable iff (!arst_n) $rose(sclk) |-> rx[0] == $past(master_in_line);
  endproperty
  a_capture: assert property (p_capture) else $error("rise sample lost");

  property p_lead;
    @(posedge clk) disable iff (!arst_n)
      $past(select_line_n) == sfb_pkg::SEL_IDLE && select_line_n != sfb_pkg::SEL_IDLE
      |-> !sclk[*4] ##1 sclk;
  endproperty
  a_lead: assert property (p_lead) else $error("lead time wrong");

  property p_lag;
    @(posedge clk) disable iff (!arst_n)
      $fell(sclk) && state == sfb_pkg::ST_LAG
      |-> select_line_n != sfb_pkg::SEL_IDLE ##1 select_line_n == sfb_pkg::SEL_IDLE;
  endproperty
  a_lag: assert property (p_lag) else $error("lag time wrong");

  property p_no_blind_program;
    @(posedge clk) disable iff (!arst_n)
      state == sfb_pkg::ST_IDLE && accept && req_slave != 2'h3 &&
      req_data == sfb_pkg::OP_PROGRAM && !erased[req_slave]
      |=> cmd_error && select_line_n == sfb_pkg::SEL_IDLE;
  endproperty
  a_no_blind_program: assert property (p_no_blind_program) else $error("program unerased");

  property p_rsp_on_fall;
    @(posedge clk) disable iff (!arst_n)
      rsp_valid |-> $fell(sclk) && bit_idx == sfb_pkg::LAST_BIT;
  endproperty
  a_rsp_on_fall: assert property (p_rsp_on_fall) else $error("byte done off its last fall");

  property p_idle_quiet;
    @(posedge clk) disable iff (!arst_n)
      state == sfb_pkg::ST_IDLE |-> !sclk && select_line_n == sfb_pkg::SEL_IDLE;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("activity while idle");

  c_frame: cover property (@(posedge clk) disable iff (!arst_n)
    state == sfb_pkg::ST_LAG ##1 state == sfb_pkg::ST_IDLE);
  c_multi_byte: cover property (@(posedge clk) disable iff (!arst_n)
    state == sfb_pkg::ST_GAP && accept);
  c_refused: cover property (@(posedge clk) disable iff (!arst_n) cmd_error);
  c_erased_program: cover property (@(posedge clk) disable iff (!arst_n)
    state == sfb_pkg::ST_IDLE && accept && req_data == sfb_pkg::OP_PROGRAM && !refuse);

endmodule : sfb_master

/* File: src/sfb_pkg.sv */
// shared constants for the serial flash boot master
package sfb_pkg;
  localparam int CLK_PERIOD_PS = 20000;
  localparam int SCLK_PERIOD_PS = 53300;
  localparam int LEAD_NOM_PS = 80000;
  localparam int LAG_NOM_PS = 13300;
  // least times round up to whole system clock cycles
  localparam int HALF_CYC = (SCLK_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LEAD_CYC = (LEAD_NOM_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LAG_CYC = (LAG_NOM_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [2:0] HALF_RELOAD = 3'(HALF_CYC - 1);
  localparam logic [2:0] LEAD_RELOAD = 3'(LEAD_CYC - 2);
  localparam logic [2:0] LAG_RELOAD = 3'(LAG_CYC - 1);
  localparam int NUM_SLAVES = 3;
  localparam logic [2:0] SEL_IDLE = 3'h7;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_ERASE_SECTOR = 8'h20;
  localparam logic [7:0] OP_ERASE_BLOCK = 8'hD8;
  localparam logic [7:0] OP_ERASE_CHIP = 8'hC7;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LEAD = 5'h02,
    ST_SHIFT = 5'h04,
    ST_GAP = 5'h08,
    ST_LAG = 5'h10
  } sfb_state_t;
endpackage : sfb_pkg

/* File: verification/sfb_flash_model.sv */
// behavioural serial flash on the far side of the boot master
module sfb_flash_model (
  input wire logic clk,
  input wire logic sclk,
  input wire logic master_out_line,
  input wire logic sel_n,
  input wire logic [7:0] tx_byte,
  output logic master_in_line,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // part size the boot image is planned for; the model keeps no array behind it
  localparam int CAPACITY_BYTES = 65536;
  logic sclk_q = 1'b0;
  logic [7:0] shift = 8'h00;
  initial rx_byte = 8'h00;
  always @(posedge clk) begin
    sclk_q <= sclk;
    if (sel_n) begin
      shift <= tx_byte;
    end else if (sclk && !sclk_q) begin
      rx_byte <= {rx_byte[6:0], master_out_line};
    end else if (!sclk && sclk_q) begin
      shift <= {shift[6:0], shift[7]};
    end
  end
  // pull-up takes the line high while deselected
  assign master_in_line = sel_n ? 1'b1 : shift[7];
endmodule : sfb_flash_model

/* File: verification/spi_flash_boot_master_bench.sv */
// self-checking bench for the serial flash boot master
module spi_flash_boot_master_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic [1:0] req_slave = 2'h0;
  logic [7:0] req_data = 8'h00;
  logic req_last = 1'b0;
  logic [7:0] tx_byte = 8'h96;
  logic req_ready, rsp_valid, cmd_error, sclk, master_out_line, master_in_line, bit7_at_rise;
  logic [7:0] rsp_data, rx_byte;
  logic [2:0] select_line_n;
  logic [7:0] ops [3] = '{sfb_pkg::OP_ERASE_SECTOR, sfb_pkg::OP_ERASE_BLOCK,
    sfb_pkg::OP_ERASE_CHIP};
  int err_count = 0;
  int compares = 0;
  int n_rsp = 0;
  int n_cerr = 0;
  time t_sel = 0;
  time t_rise = 0;
  time t_fall, t_lead, t_lag, t_hi;
  always #10 clk = ~clk;
  sfb_master dut_u (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_slave(req_slave), .req_data(req_data), .req_last(req_last), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .cmd_error(cmd_error), .sclk(sclk), .master_out_line(master_out_line),
    .master_in_line(master_in_line), .select_line_n(select_line_n));
  sfb_flash_model flash_u (.clk(clk), .sclk(sclk), .master_out_line(master_out_line),
    .sel_n(&select_line_n), .tx_byte(tx_byte), .master_in_line(master_in_line),
    .rx_byte(rx_byte));
  ////////////////////////////////////////////////////////////
  always @(negedge (&select_line_n)) t_sel = $time;
  always @(posedge sclk) begin
    // only the first rise after a select edge measures the lead
    if (t_sel > t_rise) begin
      t_lead = $time - t_sel;
      bit7_at_rise = master_out_line;
    end
    t_rise = $time;
  end
  always @(negedge sclk) begin
    t_fall = $time;
    t_hi = $time - t_rise;
  end
  always @(posedge (&select_line_n)) t_lag = $time - t_fall;
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) n_rsp++;
    if (cmd_error === 1'b1) n_cerr++;
  end
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk
  // waits until the condition holds, bounded so a hang ends the run
  task automatic wait_for(input int k);
    int n;
    n = 0;
    while ((k == 0 ? req_ready !== 1'b1 : (n_rsp < k || (&select_line_n) !== 1'b1)) &&
      n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 200) begin
      chk(32'h0, 32'h1, "timeout");
      print_verdict();
    end
  endtask : wait_for
  task automatic send(input logic [1:0] s, input logic [7:0] d, input logic l);
    req_slave = s;
    req_data = d;
    req_last = l;
    req_valid = 1'b1;
    wait_for(0);
    @(posedge clk);
    #1;
    req_valid = 1'b0;
  endtask : send
  task automatic refuse(input logic [1:0] s, input logic [7:0] d, input int k);
    send(s, d, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    chk(32'(n_cerr), 32'(k), "refusal");
    chk(32'(select_line_n), 32'(sfb_pkg::SEL_IDLE), "no frame");
    $display("refusal of slave %0d done", s);
  endtask : refuse
  task automatic run_frame(input logic [1:0] s, input logic [7:0] a, input logic [7:0] b,
    input logic two);
    int k;
    k = n_rsp + (two ? 2 : 1);
    send(s, a, !two);
    chk(32'(select_line_n), 32'(3'(~(3'h1 << s))), "select");
    // let an edge pass so valid is not dropped and raised in one step
    @(posedge clk);
    #1;
    if (two) send(s, b, 1'b1);
    wait_for(k);
    chk(32'(rx_byte), 32'(two ? b : a), "sent byte");
    chk(32'(rsp_data), 32'(tx_byte), "received byte");
    chk(32'(bit7_at_rise), 32'(a[7]), "first bit");
    chk(32'(t_lead), 32'd80, "lead");
    chk(32'(t_hi), 32'd40, "clock high");
    chk(32'(t_lag), 32'd20, "lag");
    $display("frame to slave %0d done", s);
  endtask : run_frame
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    #1;
    arst_n = 1'b1;
    chk(32'(select_line_n), 32'(sfb_pkg::SEL_IDLE), "idle select");
    chk(32'(sclk), 32'h0, "idle clock");
    refuse(2'h1, sfb_pkg::OP_PROGRAM, 1);
    refuse(2'h3, sfb_pkg::OP_ERASE_SECTOR, 2);
    for (int i = 0; i < 3; i++) begin
      run_frame(i[1:0], ops[i], 8'h00, 1'b0);
    end
    run_frame(2'h1, sfb_pkg::OP_PROGRAM, 8'h5A, 1'b1);
    print_verdict();
  end
endmodule : spi_flash_boot_master_bench
